// File: tsm_thermal_cfg.sv
`timescale 1ns/1ps
`include "tsm_cfg.svh"

module tsm_thermal_cfg import tsm_pkg::*; #(
  parameter int NUM_FANS = 3,
  parameter int NUM_TACH = 4,
  parameter logic [6:0] SLAVE_ADDR = `TSM_SMBUS_ADDR
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic config_lock,
  input wire logic signed [7:0] zone1_temp,
  input wire logic signed [7:0] zone2_temp,
  input wire logic signed [7:0] zone3_temp,
  input wire logic [NUM_FANS-1:0] fan_auto_mode,
  input wire logic [NUM_FANS-1:0] fan_disabled,
  input wire logic [NUM_FANS*8-1:0] fan_duty_in,
  output logic [NUM_FANS*8-1:0] fan_duty_out,
  output logic [NUM_FANS-1:0] fan_full_force,
  input wire logic [NUM_FANS-1:0] fan_drive_level,
  output logic [NUM_FANS-1:0] fan_drive_out,
  output logic [NUM_FANS-1:0] fan_drive_oe_n,
  input wire logic fan_drive_in_2,
  input wire logic fan_drive_in_3,
  input wire logic fan_speed_in_1,
  input wire logic fan_speed_in_2,
  input wire logic fan_speed_in_3,
  input wire logic fan_speed_in_4,
  input wire logic irq_group_request,
  output logic irq_out_n,
  output logic idle_power_select,
  output logic monitor_schedule_select,
  output logic [2:0] averaging_select,
  output logic [7:0] remote_avg_count,
  output logic [7:0] local_avg_count,
  output logic parity_test_mode,
  output logic parity_tree_out
);

  localparam int NUM_TREE = NUM_TACH + 2;

  logic [7:0] reg_addr;
  logic reg_wr_pulse;
  logic [7:0] reg_wr_data;
  logic [7:0] reg_rd_data;
  logic [7:0] zone1_limit_q, zone2_limit_q, zone3_limit_q;
  logic [7:0] parity_test_q;
  logic [7:0] special_function_reg_q;
  logic wr_ok;
  logic [NUM_TREE-1:0] tree_raw;
  logic [NUM_TREE-1:0] tree_s1_q, tree_s2_q;
  logic abs_violation;
  logic any_auto;

  // ****************************************
  // decode helpers
  // ****************************************
  function automatic logic zone_over(input logic signed [7:0] temp,
                                     input logic [7:0] limit);
    logic signed [7:0] lim_s;
    lim_s = limit;
    zone_over = (limit != `TSM_LIMIT_DISABLED) && (temp > lim_s);
  endfunction

  function automatic logic [7:0] avg_count(input logic [2:0] sel,
                                           input tsm_avg_class_t cls);
    avg_count = `TSM_AVG_32;
    if (sel[2]) begin
      avg_count = `TSM_AVG_32;
    end else if (sel[1]) begin
      avg_count = `TSM_AVG_16;
    end else if (sel[0]) begin
      avg_count = (cls == TSM_AVG_REMOTE) ? `TSM_AVG_16 : `TSM_AVG_1;
    end else begin
      avg_count = (cls == TSM_AVG_REMOTE) ? `TSM_AVG_128 : `TSM_AVG_8;
    end
  endfunction

  // ****************************************
  // serial register access
  // ****************************************
  tsm_smbus_slave #(
    .SLAVE_ADDR(SLAVE_ADDR)
  ) u_bus (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe_n(sda_oe_n),
    .reg_addr(reg_addr),
    .reg_wr_pulse(reg_wr_pulse),
    .reg_wr_data(reg_wr_data),
    .reg_rd_data(reg_rd_data)
  );

  assign wr_ok = reg_wr_pulse && !config_lock;

  // ****************************************
  // limit registers
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      zone1_limit_q <= `TSM_RST_ABS_LIMIT;
      zone2_limit_q <= `TSM_RST_ABS_LIMIT;
      zone3_limit_q <= `TSM_RST_ABS_LIMIT;
    end else if (wr_ok) begin
      if (reg_addr == `TSM_OFS_ZONE1_ABS_LIMIT) begin
        zone1_limit_q <= reg_wr_data;
      end
      if (reg_addr == `TSM_OFS_ZONE2_ABS_LIMIT) begin
        zone2_limit_q <= reg_wr_data;
      end
      if (reg_addr == `TSM_OFS_ZONE3_ABS_LIMIT) begin
        zone3_limit_q <= reg_wr_data;
      end
    end
  end

  // ****************************************
  // parity test and special function
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      parity_test_q <= `TSM_RST_PARITY_TEST;
    end else if (wr_ok && reg_addr == `TSM_OFS_PARITY_TEST) begin
      parity_test_q <= {7'h00, reg_wr_data[`TSM_BIT_PARITY_TEST_EN]};
    end
  end

  // bits 3 and 4 are stored as written; software keeps them zero
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      special_function_reg_q <= `TSM_RST_SPECIAL_FUNCTION;
    end else if (wr_ok && reg_addr == `TSM_OFS_SPECIAL_FUNCTION) begin
      special_function_reg_q <= reg_wr_data;
    end
  end

  // ****************************************
  // read mux
  // ****************************************
  always_comb begin
    case (reg_addr)
      `TSM_OFS_ZONE1_ABS_LIMIT: reg_rd_data = zone1_limit_q;
      `TSM_OFS_ZONE2_ABS_LIMIT: reg_rd_data = zone2_limit_q;
      `TSM_OFS_ZONE3_ABS_LIMIT: reg_rd_data = zone3_limit_q;
      `TSM_OFS_PARITY_TEST: reg_rd_data = parity_test_q;
      `TSM_OFS_SPECIAL_FUNCTION: reg_rd_data = special_function_reg_q;
      default: reg_rd_data = `TSM_READ_UNMAPPED;
    endcase
  end

  // ****************************************
  // absolute limit safety
  // ****************************************
  assign any_auto = |fan_auto_mode;
  assign abs_violation = any_auto && (zone_over(zone1_temp, zone1_limit_q) ||
                                      zone_over(zone2_temp, zone2_limit_q) ||
                                      zone_over(zone3_temp, zone3_limit_q));

  genvar gi;
  generate
    for (gi = 0; gi < NUM_FANS; gi++) begin : g_fan
      always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
          fan_full_force[gi] <= 1'b0;
          fan_duty_out[gi*8 +: 8] <= 8'h00;
        end else begin
          // manual fans included, disabled ones left alone
          fan_full_force[gi] <= abs_violation && !fan_disabled[gi];
          if (abs_violation && !fan_disabled[gi]) begin
            fan_duty_out[gi*8 +: 8] <= `TSM_DUTY_FULL;
          end else begin
            fan_duty_out[gi*8 +: 8] <= fan_duty_in[gi*8 +: 8];
          end
        end
      end

      // drive pins 2 and 3 turn into tree inputs during test
      always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
          fan_drive_out[gi] <= 1'b0;
          fan_drive_oe_n[gi] <= 1'b0;
        end else begin
          fan_drive_out[gi] <= fan_drive_level[gi];
          fan_drive_oe_n[gi] <= (gi != 0) && parity_test_q[`TSM_BIT_PARITY_TEST_EN];
        end
      end
    end
  endgenerate

  // ****************************************
  // parity tree
  // ****************************************
  // bus lines are deliberately absent from the tree
  assign tree_raw = {fan_drive_in_3, fan_drive_in_2, fan_speed_in_4,
                     fan_speed_in_3, fan_speed_in_2, fan_speed_in_1};

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      tree_s1_q <= '0;
      tree_s2_q <= '0;
    end else begin
      tree_s1_q <= tree_raw;
      tree_s2_q <= tree_s1_q;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      parity_test_mode <= 1'b0;
      parity_tree_out <= 1'b0;
    end else begin
      parity_test_mode <= parity_test_q[`TSM_BIT_PARITY_TEST_EN];
      parity_tree_out <= parity_test_q[`TSM_BIT_PARITY_TEST_EN] & (^tree_s2_q);
    end
  end

  // ****************************************
  // mode and averaging outputs
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      idle_power_select <= 1'b0;
      monitor_schedule_select <= 1'b0;
    end else begin
      idle_power_select <= special_function_reg_q[`TSM_BIT_IDLE_POWER];
      monitor_schedule_select <= special_function_reg_q[`TSM_BIT_MONITOR_SCHED];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      averaging_select <= 3'h2;
      remote_avg_count <= `TSM_AVG_16;
      local_avg_count <= `TSM_AVG_16;
    end else begin
      averaging_select <= special_function_reg_q[`TSM_AVG_HI:`TSM_AVG_LO];
      remote_avg_count <= avg_count(special_function_reg_q[`TSM_AVG_HI:`TSM_AVG_LO],
                                    TSM_AVG_REMOTE);
      local_avg_count <= avg_count(special_function_reg_q[`TSM_AVG_HI:`TSM_AVG_LO],
                                   TSM_AVG_LOCAL);
    end
  end

  // ****************************************
  // interrupt pin
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      irq_out_n <= 1'b1;
    end else begin
      irq_out_n <= ~(irq_group_request & special_function_reg_q[`TSM_BIT_GLOBAL_IRQ]);
    end
  end

endmodule // tsm_thermal_cfg

// File: tsm_cfg.svh
// How it works
// - lock set makes limit, parity test and special function registers ignore writes.
// - auto mode zone over its limit forces every non-disabled drive to full duty.
// - with any fan in auto, manual non-disabled fans are forced full too.
// - every zone is checked, including zones tied to no fan.
// - a limit of 80h never triggers the full-speed safety action.
// - three 8-bit read/write zone limits, each resetting to 64h.
// - bit 0 of the parity test register enables tree test; reset 00h.
// - tree holds four speed inputs and drive pins 2 and 3, not bus lines.
// - tree output is pure parity, so input order is irrelevant.
// - bit 0 selects idle state: zero sleep, one deeper low power.
// - bit 1 selects monitoring: zero continuous, one cycling.
// - bit 2 is global interrupt enable; interrupt pin acts only while set.
// - averaging field bits 7:5 sets averages per measurement per table.
// - averaging field top bit set gives 32 averages for everything.
// - averaging field resets to 010, register resets to 40h.
// - interrupt pin is active low, pulled low by enabled group and enable.
`ifndef TSM_CFG_SVH
`define TSM_CFG_SVH

// ****************************************
// register offsets
// ****************************************
`define TSM_OFS_ZONE1_ABS_LIMIT 8'h6A
`define TSM_OFS_ZONE2_ABS_LIMIT 8'h6B
`define TSM_OFS_ZONE3_ABS_LIMIT 8'h6C
`define TSM_OFS_PARITY_TEST 8'h6F
`define TSM_OFS_SPECIAL_FUNCTION 8'h7C

// ****************************************
// reset values
// ****************************************
`define TSM_RST_ABS_LIMIT 8'h64
`define TSM_RST_PARITY_TEST 8'h00
`define TSM_RST_SPECIAL_FUNCTION 8'h40

// ****************************************
// field positions
// ****************************************
`define TSM_BIT_PARITY_TEST_EN 0
`define TSM_BIT_IDLE_POWER 0
`define TSM_BIT_MONITOR_SCHED 1
`define TSM_BIT_GLOBAL_IRQ 2
`define TSM_AVG_HI 7
`define TSM_AVG_LO 5

// ****************************************
// values
// ****************************************
`define TSM_LIMIT_DISABLED 8'h80
`define TSM_DUTY_FULL 8'hFF
`define TSM_AVG_128 8'h80
`define TSM_AVG_32 8'h20
`define TSM_AVG_16 8'h10
`define TSM_AVG_8 8'h08
`define TSM_AVG_1 8'h01
`define TSM_SMBUS_ADDR 7'h2E
`define TSM_READ_UNMAPPED 8'h00

`endif

// File: tsm_pkg.sv
package tsm_pkg;

  typedef enum logic [8:0] {
    TSM_ST_IDLE = 9'h001,
    TSM_ST_ADDR = 9'h002,
    TSM_ST_ACK_ADDR = 9'h004,
    TSM_ST_CMD = 9'h008,
    TSM_ST_ACK_CMD = 9'h010,
    TSM_ST_WDATA = 9'h020,
    TSM_ST_ACK_WDATA = 9'h040,
    TSM_ST_RDATA = 9'h080,
    TSM_ST_RACK = 9'h100
  } tsm_bus_state_t;

  typedef enum logic [1:0] {
    TSM_AVG_REMOTE = 2'h1,
    TSM_AVG_LOCAL = 2'h2
  } tsm_avg_class_t;

endpackage

// File: tsm_smbus_slave.sv
`timescale 1ns/1ps
`include "tsm_cfg.svh"

module tsm_smbus_slave import tsm_pkg::*; #(
  parameter logic [6:0] SLAVE_ADDR = `TSM_SMBUS_ADDR
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  output logic [7:0] reg_addr,
  output logic reg_wr_pulse,
  output logic [7:0] reg_wr_data,
  input wire logic [7:0] reg_rd_data
);

  logic scl_s1_q, scl_s2_q, scl_s3_q;
  logic sda_s1_q, sda_s2_q, sda_s3_q;
  tsm_bus_state_t state_q;
  logic [3:0] cnt_q;
  logic [7:0] shift_q;
  logic [7:0] tx_q;
  logic rw_q;
  logic drive_q;
  logic scl_rise, scl_fall, start_det, stop_det, byte_fall;

  // ****************************************
  // pin synchronisers
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      scl_s3_q <= 1'b1;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
      sda_s3_q <= 1'b1;
    end else begin
      scl_s1_q <= scl_in;
      scl_s2_q <= scl_s1_q;
      scl_s3_q <= scl_s2_q;
      sda_s1_q <= sda_in;
      sda_s2_q <= sda_s1_q;
      sda_s3_q <= sda_s2_q;
    end
  end

  assign scl_rise = scl_s2_q & ~scl_s3_q;
  assign scl_fall = ~scl_s2_q & scl_s3_q;
  assign start_det = scl_s2_q & scl_s3_q & sda_s3_q & ~sda_s2_q;
  assign stop_det = scl_s2_q & scl_s3_q & ~sda_s3_q & sda_s2_q;
  assign byte_fall = scl_fall & (cnt_q == 4'h8);

  // ****************************************
  // byte framing
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      state_q <= TSM_ST_IDLE;
      cnt_q <= 4'h0;
      shift_q <= 8'h00;
      tx_q <= 8'h00;
      rw_q <= 1'b0;
      drive_q <= 1'b0;
    end else if (start_det) begin
      state_q <= TSM_ST_ADDR;
      cnt_q <= 4'h0;
      drive_q <= 1'b0;
    end else if (stop_det) begin
      state_q <= TSM_ST_IDLE;
      drive_q <= 1'b0;
    end else begin
      case (state_q)
        TSM_ST_ADDR, TSM_ST_CMD, TSM_ST_WDATA: begin
          if (scl_rise && cnt_q != 4'h8) begin
            shift_q <= {shift_q[6:0], sda_s2_q};
            cnt_q <= cnt_q + 4'h1;
          end
          if (byte_fall) begin
            if (state_q == TSM_ST_ADDR && shift_q[7:1] != SLAVE_ADDR) begin
              state_q <= TSM_ST_IDLE;
            end else begin
              drive_q <= 1'b1;
              if (state_q == TSM_ST_ADDR) begin
                rw_q <= shift_q[0];
                state_q <= TSM_ST_ACK_ADDR;
              end else if (state_q == TSM_ST_CMD) begin
                state_q <= TSM_ST_ACK_CMD;
              end else begin
                state_q <= TSM_ST_ACK_WDATA;
              end
            end
          end
        end
        TSM_ST_ACK_ADDR: begin
          if (scl_fall) begin
            if (rw_q) begin
              tx_q <= reg_rd_data;
              drive_q <= ~reg_rd_data[7];
              cnt_q <= 4'h1;
              state_q <= TSM_ST_RDATA;
            end else begin
              drive_q <= 1'b0;
              cnt_q <= 4'h0;
              state_q <= TSM_ST_CMD;
            end
          end
        end
        TSM_ST_ACK_CMD, TSM_ST_ACK_WDATA: begin
          if (scl_fall) begin
            drive_q <= 1'b0;
            cnt_q <= 4'h0;
            state_q <= TSM_ST_WDATA;
          end
        end
        TSM_ST_RDATA: begin
          if (scl_fall) begin
            if (cnt_q == 4'h8) begin
              drive_q <= 1'b0;
              state_q <= TSM_ST_RACK;
            end else begin
              drive_q <= ~tx_q[6];
              tx_q <= {tx_q[6:0], 1'b0};
              cnt_q <= cnt_q + 4'h1;
            end
          end
        end
        TSM_ST_RACK: begin
          // master nack ends the read, ack loads the next byte
          if (scl_rise && sda_s2_q) begin
            state_q <= TSM_ST_IDLE;
          end else if (scl_fall) begin
            tx_q <= reg_rd_data;
            drive_q <= ~reg_rd_data[7];
            cnt_q <= 4'h1;
            state_q <= TSM_ST_RDATA;
          end
        end
        TSM_ST_IDLE: begin
          drive_q <= 1'b0;
        end
        default: begin
          state_q <= TSM_ST_IDLE;
          drive_q <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************
  // register pointer and write strobe
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      reg_addr <= 8'h00;
    end else if (state_q == TSM_ST_CMD && byte_fall) begin
      reg_addr <= shift_q;
    end else if ((state_q == TSM_ST_ACK_WDATA && scl_fall) ||
                 (state_q == TSM_ST_RACK && scl_rise && !sda_s2_q)) begin
      reg_addr <= reg_addr + 8'h01;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      reg_wr_pulse <= 1'b0;
      reg_wr_data <= 8'h00;
    end else begin
      reg_wr_pulse <= (state_q == TSM_ST_WDATA) && byte_fall;
      if ((state_q == TSM_ST_WDATA) && byte_fall) begin
        reg_wr_data <= shift_q;
      end
    end
  end

  // open drain: only ever pulls low
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      sda_out <= 1'b0;
      sda_oe_n <= 1'b1;
    end else begin
      sda_out <= 1'b0;
      sda_oe_n <= ~drive_q;
    end
  end

endmodule // tsm_smbus_slave

// File: tsm_smbus_host.sv
`timescale 1ns/1ps
module tsm_smbus_host #(
  parameter logic [6:0] DEV_ADDR = 7'h2E
) (
  input wire logic sys_clk,
  input wire logic sda_line,
  output logic scl_drv,
  output logic sda_drv
);
  // ****
  // bus idles released, quarter bit is 10 cycles
  // ****
  initial begin
    scl_drv = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic q;
    repeat (10) @(negedge sys_clk);
  endtask
  task automatic put(input logic b);
    sda_drv = b;
    q();
    scl_drv = 1'b1;
    q();
    q();
    scl_drv = 1'b0;
    q();
  endtask
  task automatic get(output logic b);
    sda_drv = 1'b1;
    q();
    scl_drv = 1'b1;
    q();
    b = sda_line;
    q();
    scl_drv = 1'b0;
    q();
  endtask
  task automatic start;
    sda_drv = 1'b1;
    q();
    scl_drv = 1'b1;
    q();
    sda_drv = 1'b0;
    q();
    scl_drv = 1'b0;
    q();
  endtask
  task automatic stop;
    sda_drv = 1'b0;
    q();
    scl_drv = 1'b1;
    q();
    sda_drv = 1'b1;
    q();
  endtask
  task automatic tx(input logic [7:0] d);
    logic n;
    for (int i = 7; i >= 0; i--) put(d[i]);
    get(n);
  endtask
  task automatic rx(output logic [7:0] d);
    for (int i = 7; i >= 0; i--) get(d[i]);
    put(1'b1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    start();
    tx({DEV_ADDR, 1'b0});
    tx(a);
    tx(d);
    stop();
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    start();
    tx({DEV_ADDR, 1'b0});
    tx(a);
    start();
    tx({DEV_ADDR, 1'b1});
    rx(d);
    stop();
  endtask
endmodule // tsm_smbus_host

// File: tsm_thermal_cfg_checker.sv
`timescale 1ns/1ps
module tsm_thermal_cfg_checker #(
  parameter int NUM_FANS = 3
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic config_lock,
  input wire logic [NUM_FANS-1:0] fan_auto_mode,
  input wire logic [NUM_FANS-1:0] fan_disabled,
  input wire logic [NUM_FANS*8-1:0] fan_duty_in,
  input wire logic [NUM_FANS*8-1:0] fan_duty_out,
  input wire logic [NUM_FANS-1:0] fan_full_force,
  input wire logic [NUM_FANS-1:0] fan_drive_oe_n,
  input wire logic irq_group_request,
  input wire logic irq_out_n,
  input wire logic [2:0] averaging_select,
  input wire logic [7:0] remote_avg_count,
  input wire logic [7:0] local_avg_count,
  input wire logic parity_test_mode,
  input wire logic parity_tree_out
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);
  for (genvar i = 0; i < NUM_FANS; i++) begin : g_fan
    a_force_full: assert property (
      fan_full_force[i] |-> fan_duty_out[8*i+:8] == 8'hFF) else $error("forced duty");
    a_disabled_free: assert property (
      fan_disabled[i] |=> !fan_full_force[i]) else $error("disabled forced");
    a_unforced_pass: assert property (
      $past(rst_b) && !fan_full_force[i] |-> fan_duty_out[8*i+:8] == $past(fan_duty_in[8*i+:8]))
      else $error("duty pass");
  end
  a_no_auto: assert property (
    fan_auto_mode == '0 |=> fan_full_force == '0) else $error("force without auto");
  a_avg_top: assert property (
    averaging_select[2] |-> remote_avg_count == 8'h20 && local_avg_count == 8'h20)
    else $error("avg top");
  a_avg_zero: assert property (
    averaging_select == 3'b000 |-> remote_avg_count == 8'h80 && local_avg_count == 8'h08)
    else $error("avg zero");
  a_tree_quiet: assert property (
    !parity_test_mode && !$past(parity_test_mode) |-> !parity_tree_out) else $error("tree");
  a_tree_release: assert property (
    parity_test_mode && $past(parity_test_mode) |-> fan_drive_oe_n[2:0] == 3'b110)
    else $error("tree pins");
  a_irq_idle: assert property (
    !irq_group_request |=> irq_out_n) else $error("irq low");
  a_lock_hold: assert property (
    config_lock && $past(config_lock) && $past(config_lock, 2)
    |-> $stable(averaging_select) && $stable(parity_test_mode)) else $error("locked");
endmodule // tsm_thermal_cfg_checker

bind tsm_thermal_cfg tsm_thermal_cfg_checker #(.NUM_FANS(NUM_FANS)) chk_u (
  .sys_clk(sys_clk), .rst_b(rst_b), .config_lock(config_lock),
  .fan_auto_mode(fan_auto_mode), .fan_disabled(fan_disabled),
  .fan_duty_in(fan_duty_in), .fan_duty_out(fan_duty_out),
  .fan_full_force(fan_full_force), .fan_drive_oe_n(fan_drive_oe_n),
  .irq_group_request(irq_group_request), .irq_out_n(irq_out_n),
  .averaging_select(averaging_select), .remote_avg_count(remote_avg_count),
  .local_avg_count(local_avg_count), .parity_test_mode(parity_test_mode),
  .parity_tree_out(parity_tree_out));

// File: tb_tsm_thermal_cfg.sv
`timescale 1ns/1ps
module tb_tsm_thermal_cfg;
  import tsm_pkg::*;
  logic sys_clk = 1'b0, rst_b = 1'b0, config_lock = 1'b0, irq_group_request = 1'b0;
  logic signed [7:0] zone1_temp = 8'h00, zone2_temp = 8'h00, zone3_temp = 8'h00;
  logic [2:0] fan_auto_mode = 3'h0, fan_disabled = 3'h0, fan_drive_level = 3'h0;
  logic [23:0] fan_duty_in = 24'h0, dx;
  logic [5:0] tree_in = 6'h00;
  wire scl_in, sda_m, sda_in, sda_out, sda_oe_n, irq_out_n, idle_power_select;
  wire monitor_schedule_select, parity_test_mode, parity_tree_out;
  wire [23:0] fan_duty_out;
  wire [2:0] fan_full_force, fan_drive_out, fan_drive_oe_n, averaging_select;
  wire [7:0] remote_avg_count, local_avg_count;
  int seed = 12, n_mismatch = 0, checks_done = 0, cycle_cnt = 0;
  logic [31:0] exp_q[$], seen;
  string nm_q[$];
  event seen_ev;
  logic [7:0] v, r, l;
  logic [2:0] f;
  logic hit;
  logic [7:0] ra[5] = '{8'h6A, 8'h6B, 8'h6C, 8'h6F, 8'h7C};
  logic [7:0] re[5] = '{8'h64, 8'h64, 8'h64, 8'h00, 8'h40};

  always #25 sys_clk = ~sys_clk;
  // open drain data line with pull-up
  assign sda_in = sda_m & (sda_oe_n | sda_out);

  tsm_smbus_host host_u (.sys_clk(sys_clk), .sda_line(sda_in), .scl_drv(scl_in),
    .sda_drv(sda_m));
  tsm_thermal_cfg dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .scl_in(scl_in),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .config_lock(config_lock),
    .zone1_temp(zone1_temp), .zone2_temp(zone2_temp), .zone3_temp(zone3_temp),
    .fan_auto_mode(fan_auto_mode), .fan_disabled(fan_disabled), .fan_duty_in(fan_duty_in),
    .fan_duty_out(fan_duty_out), .fan_full_force(fan_full_force),
    .fan_drive_level(fan_drive_level), .fan_drive_out(fan_drive_out),
    .fan_drive_oe_n(fan_drive_oe_n), .fan_drive_in_2(tree_in[4]),
    .fan_drive_in_3(tree_in[5]), .fan_speed_in_1(tree_in[0]), .fan_speed_in_2(tree_in[1]),
    .fan_speed_in_3(tree_in[2]), .fan_speed_in_4(tree_in[3]),
    .irq_group_request(irq_group_request), .irq_out_n(irq_out_n),
    .idle_power_select(idle_power_select), .monitor_schedule_select(monitor_schedule_select),
    .averaging_select(averaging_select), .remote_avg_count(remote_avg_count),
    .local_avg_count(local_avg_count), .parity_test_mode(parity_test_mode),
    .parity_tree_out(parity_tree_out));

  // ****
  // result bookkeeping
  // ****
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %0h seen %0h", n, e, s);
    end
  endtask
  task outc(input string n, input logic [31:0] e, input logic [31:0] s);
    nm_q.push_back(n);
    exp_q.push_back(e);
    seen = s;
    ->seen_ev;
    #1;
  endtask
  task rdc(input string n, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host_u.rd(a, d);
    outc(n, 32'(e), 32'(d));
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always begin
    @(seen_ev);
    chk(nm_q.pop_front(), seen, exp_q.pop_front());
  end
  always @(posedge sys_clk) begin
    cycle_cnt++;
    if (cycle_cnt == 80000) begin
      n_mismatch++;
      summarize();
    end
  end

  // ****
  // scenarios
  // ****
  initial begin
    repeat (3) @(negedge sys_clk);
    rst_b = 1'b1;
    repeat (3) @(negedge sys_clk);
    for (int i = 0; i < 5; i++) rdc("reset", ra[i], re[i]);
    outc("avg_rst", 32'h1010, 32'({remote_avg_count, local_avg_count}));
    $display("test reset done");
    host_u.wr(8'h6A, 8'h55);
    host_u.wr(8'h6F, 8'hFE);
    rdc("lim1", 8'h6A, 8'h55);
    rdc("ptest", 8'h6F, 8'h00);
    rdc("unmapped", 8'h70, 8'h00);
    $display("test access done");
    for (int i = 0; i < 8; i++) begin
      v = {i[2:0], 3'b000, 2'($random(seed))}; // bits 3,4 left zero
      host_u.wr(8'h7C, v);
      repeat (2) @(negedge sys_clk);
      r = i[2] ? 8'h20 : (i[1:0] != 0 ? 8'h10 : 8'h80);
      l = i[2] ? 8'h20 : (i[1] ? 8'h10 : (i[0] ? 8'h01 : 8'h08));
      outc("avg", {r, l, 8'(i), 6'h0, v[1:0]}, {remote_avg_count, local_avg_count, 5'h0,
        averaging_select, 6'h0, monitor_schedule_select, idle_power_select});
    end
    $display("test modes done");
    for (int i = 0; i < 4; i++) begin
      irq_group_request = i[0];
      host_u.wr(8'h7C, 8'h40 | {5'h0, i[1], 2'h0});
      repeat (2) @(negedge sys_clk);
      outc("irq", 32'(!(i[0] && i[1])), 32'(irq_out_n));
    end
    $display("test irq done");
    host_u.wr(8'h6B, 8'h80);
    host_u.wr(8'h6C, 8'h7F);
    for (int k = 0; k < 60; k++) begin
      zone1_temp = 8'($random(seed));
      zone2_temp = 8'($random(seed));
      zone3_temp = 8'($random(seed));
      {fan_auto_mode, fan_disabled} = 6'($random(seed));
      fan_duty_in = 24'($random(seed));
      @(negedge sys_clk);
      hit = zone1_temp > 8'sh55 || zone3_temp > 8'sh7F;
      f = (|fan_auto_mode && hit) ? ~fan_disabled : 3'h0;
      for (int j = 0; j < 3; j++) dx[8*j+:8] = f[j] ? 8'hFF : fan_duty_in[8*j+:8];
      outc("force", {5'h0, f, dx}, {5'h0, fan_full_force, fan_duty_out});
    end
    $display("test safety done");
    config_lock = 1'b1;
    host_u.wr(8'h6A, 8'h11);
    host_u.wr(8'h7C, 8'hE0);
    host_u.wr(8'h6F, 8'h01);
    rdc("lim_lock", 8'h6A, 8'h55);
    rdc("sf_lock", 8'h7C, 8'h44);
    rdc("pt_lock", 8'h6F, 8'h00);
    config_lock = 1'b0;
    $display("test lock done");
    host_u.wr(8'h6F, 8'h01);
    for (int k = 0; k < 20; k++) begin
      tree_in = 6'($random(seed));
      fan_drive_level = 3'($random(seed));
      repeat (4) @(negedge sys_clk);
      outc("tree", 32'({1'b1, ^tree_in, 3'b110, fan_drive_level}), 32'({parity_test_mode,
        parity_tree_out, fan_drive_oe_n, fan_drive_out}));
    end
    $display("test tree done");
    summarize();
  end
endmodule // tb_tsm_thermal_cfg
